// ===== pot_port_regs.vh
// constants for the two-wire slave port of the potentiometer device
`ifndef POT_PORT_REGS_VH
`define POT_PORT_REGS_VH

// ----------------------------------------------------------------
// control byte layout
// ----------------------------------------------------------------
`define TYPE_CODE_MSB 7
`define TYPE_CODE_LSB 2
`define SELECT_BIT 1
`define DIR_BIT 0
`define DIR_READ 1'b1
`define DIR_WRITE 1'b0

// ----------------------------------------------------------------
// address pointer
// ----------------------------------------------------------------
`define ADDR_RESET 8'h00
`define ADDR_LAST 8'hff

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLOCK_PERIOD_NS 5
`define FAST_SCL_PERIOD_NS 2500
`define STD_SCL_PERIOD_NS 10000
`define BITS_PER_BYTE 4'd8

`endif

// ===== line_sync.v
// two-flop synchroniser with edge detection for one bus line
`timescale 1ns/1ps

module line_sync
(
    input wire clock,
    input wire rstn,
    input wire enable,
    input wire line_in,
    output reg level,
    output wire rise,
    output wire fall
);

reg meta;
reg prev;

// only the second flop and later stages are looked at
always @(posedge clock or negedge rstn)
begin
    if (!rstn)
    begin
        meta <= 1'b1;
        level <= 1'b1;
        prev <= 1'b1;
    end
    else if (enable)
    begin
        meta <= line_in;
        level <= meta;
        prev <= level;
    end
end

assign rise = level & ~prev;
assign fall = ~level & prev;

endmodule // line_sync

// ===== pot_two_wire_slave_port.v
// two-wire slave port: control byte decode, receive and transmit paths
`timescale 1ns/1ps
`include "pot_port_regs.vh"

module pot_two_wire_slave_port
#(
    parameter [5:0] TYPE_CODE = 6'h15, // arbitrary type code
    parameter ADDR_WIDTH = 8
)
(
    input wire clock,
    input wire rstn,
    input wire clock_enable,
    input wire scl_in,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe,
    input wire addr_select_pin,
    input wire [7:0] read_data,
    output reg [ADDR_WIDTH-1:0] mem_addr,
    output reg [7:0] write_data,
    output reg write_strobe,
    output reg busy
);

// ----------------------------------------------------------------
// states
// ----------------------------------------------------------------
localparam [2:0] st_idle = 3'd0;
localparam [2:0] st_ctrl = 3'd1;
localparam [2:0] st_ack = 3'd2;
localparam [2:0] st_rx = 3'd3;
localparam [2:0] st_tx = 3'd4;
localparam [2:0] st_mack = 3'd5;

// ----------------------------------------------------------------
// line synchronisers
// ----------------------------------------------------------------
wire scl;
wire scl_rise;
wire scl_fall;
wire sda;
wire sda_rise;
wire sda_fall;

// a 5 ns sample clock sees many samples per fast-mode bit
line_sync u_scl_sync
(
    .clock(clock),
    .rstn(rstn),
    .enable(clock_enable),
    .line_in(scl_in),
    .level(scl),
    .rise(scl_rise),
    .fall(scl_fall)
);

line_sync u_sda_sync
(
    .clock(clock),
    .rstn(rstn),
    .enable(clock_enable),
    .line_in(sda_in),
    .level(sda),
    .rise(sda_rise),
    .fall(sda_fall)
);

// scl delayed to match the sda edge stage
reg scl_d;
always @(posedge clock or negedge rstn)
begin
    if (!rstn)
        scl_d <= 1'b1;
    else if (clock_enable)
        scl_d <= scl;
end

// data edges under a high clock are control, never data
wire start_seen = sda_fall & scl & scl_d;
wire stop_seen = sda_rise & scl & scl_d;

// ----------------------------------------------------------------
// protocol engine
// ----------------------------------------------------------------
reg [2:0] state;
reg [3:0] bit_count;
reg [7:0] shift;
reg dir_read;
reg first_data;
reg ack_pending;

wire [7:0] rx_byte = {shift[6:0], sda};
wire type_ok = rx_byte[`TYPE_CODE_MSB:`TYPE_CODE_LSB] == TYPE_CODE;
wire select_ok = rx_byte[`SELECT_BIT] == addr_select_pin;
wire addr_match = type_ok & select_ok;

// ----------------------------------------------------------------
// bit counter events
// ----------------------------------------------------------------
wire byte_done = scl_fall && (bit_count == `BITS_PER_BYTE);
wire ctrl_last_rise = (state == st_ctrl) && scl_rise && (bit_count == 4'd7);

// ----------------------------------------------------------------
// control byte match latched on the eighth rising edge
// ----------------------------------------------------------------
reg type_ok_hold;
always @(posedge clock or negedge rstn)
begin
    if (!rstn)
        type_ok_hold <= 1'b0;
    else if (clock_enable && ctrl_last_rise)
        type_ok_hold <= addr_match;
end

// ----------------------------------------------------------------
// pointer next value, wraps from the top address to zero
// ----------------------------------------------------------------
localparam [ADDR_WIDTH-1:0] addr_one = {{(ADDR_WIDTH-1){1'b0}}, 1'b1};
localparam [ADDR_WIDTH-1:0] addr_top = {ADDR_WIDTH{1'b1}};
reg [ADDR_WIDTH-1:0] next_addr;

always @*
begin
    if (mem_addr == addr_top)
        next_addr = {ADDR_WIDTH{1'b0}};
    else
        next_addr = mem_addr + addr_one;
end

always @(posedge clock or negedge rstn)
begin
    if (!rstn)
    begin
        state <= st_idle;
        bit_count <= 4'd0;
        shift <= 8'h00;
        dir_read <= 1'b0;
        first_data <= 1'b0;
        ack_pending <= 1'b0;
        sda_oe <= 1'b0;
        mem_addr <= `ADDR_RESET;
    end
    else if (clock_enable)
    begin
        if (start_seen)
        begin
            // a repeated start simply restarts decoding
            state <= st_ctrl;
            bit_count <= 4'd0;
            sda_oe <= 1'b0;
            ack_pending <= 1'b0;
        end
        else if (stop_seen)
        begin
            state <= st_idle;
            sda_oe <= 1'b0;
        end
        else
        begin
            case (state)
                st_idle:
                begin
                    sda_oe <= 1'b0;
                end
                st_ctrl, st_rx:
                begin
                    if (scl_rise)
                    begin
                        shift <= rx_byte;
                        bit_count <= bit_count + 4'd1;
                    end
                    if (byte_done)
                    begin
                        bit_count <= 4'd0;
                        if (state == st_ctrl)
                        begin
                            if (type_ok_hold)
                            begin
                                dir_read <= shift[`DIR_BIT] == `DIR_READ;
                                first_data <= 1'b1;
                                sda_oe <= 1'b1;
                                state <= st_ack;
                            end
                            else
                            begin
                                state <= st_idle;
                            end
                        end
                        else
                        begin
                            if (first_data)
                                mem_addr <= shift;
                            else
                            begin
                                mem_addr <= next_addr;
                            end
                            first_data <= 1'b0;
                            sda_oe <= 1'b1;
                            state <= st_ack;
                        end
                    end
                end
                st_ack:
                begin
                    // held low through the whole high phase; on the fall freed for a write, set to the first data bit for a read
                    if (scl_fall)
                    begin
                        sda_oe <= 1'b0;
                        if (dir_read)
                        begin
                            state <= st_tx;
                            bit_count <= 4'd1;
                            shift <= {read_data[6:0], 1'b0};
                            sda_oe <= ~read_data[7];
                        end
                        else
                            state <= st_rx;
                    end
                end
                st_tx:
                begin
                    if (scl_fall)
                    begin
                        if (bit_count == `BITS_PER_BYTE)
                        begin
                            sda_oe <= 1'b0;
                            mem_addr <= next_addr;
                            state <= st_mack;
                        end
                        else
                        begin
                            sda_oe <= ~shift[7];
                            shift <= {shift[6:0], 1'b0};
                            bit_count <= bit_count + 4'd1;
                        end
                    end
                end
                st_mack:
                begin
                    if (scl_rise)
                        ack_pending <= ~sda;
                    if (scl_fall)
                    begin
                        if (ack_pending)
                        begin
                            state <= st_tx;
                            bit_count <= 4'd1;
                            shift <= {read_data[6:0], 1'b0};
                            sda_oe <= ~read_data[7];
                        end
                        else
                        begin
                            // line stays released for the master's stop
                            state <= st_idle;
                            sda_oe <= 1'b0;
                        end
                    end
                end
                default:
                begin
                    state <= st_idle;
                    sda_oe <= 1'b0;
                end
            endcase
        end
    end
end

// ----------------------------------------------------------------
// write port: every byte after the address byte is strobed out
// ----------------------------------------------------------------
wire write_take = (state == st_rx) && byte_done && !first_data
    && !start_seen && !stop_seen;

always @(posedge clock or negedge rstn)
begin
    if (!rstn)
    begin
        write_data <= 8'h00;
        write_strobe <= 1'b0;
    end
    else if (clock_enable)
    begin
        write_strobe <= write_take;
        if (write_take)
            write_data <= shift;
    end
end

// ----------------------------------------------------------------
// busy flag: start to stop, dropped early on a refused control byte
// ----------------------------------------------------------------
wire refuse = (state == st_ctrl) && byte_done && !type_ok_hold;

// start wins over everything, so a repeated start never drops busy
always @(posedge clock or negedge rstn)
begin
    if (!rstn)
        busy <= 1'b0;
    else if (clock_enable)
    begin
        if (start_seen)
            busy <= 1'b1;
        else if (stop_seen || refuse)
            busy <= 1'b0;
    end
end

// ----------------------------------------------------------------
// pad value: open drain, so only the enable ever moves
// ----------------------------------------------------------------
always @(posedge clock or negedge rstn)
begin
    if (!rstn)
        sda_out <= 1'b0;
    else if (clock_enable)
        sda_out <= 1'b0;
end

endmodule // pot_two_wire_slave_port

// ===== pot_port_monitor.sv
// checker for the two-wire slave port, bound to its ports
`timescale 1ns/1ps

module pot_port_monitor
#(
    parameter [5:0] TYPE_CODE = 6'h15,
    parameter ADDR_WIDTH = 8
)
(
    input wire clock,
    input wire rstn,
    input wire clock_enable,
    input wire scl_in,
    input wire sda_in,
    input wire sda_out,
    input wire sda_oe,
    input wire addr_select_pin,
    input wire [7:0] read_data,
    input wire [ADDR_WIDTH-1:0] mem_addr,
    input wire [7:0] write_data,
    input wire write_strobe,
    input wire busy
);
    // ------------------------------------------------
    // assertions
    // ------------------------------------------------
    default clocking mon_clk @(posedge clock);
    endclocking
    default disable iff (!rstn);

    AST_SDA_LOW_ONLY: assert property (sda_out == 1'b0)
        else $error("data output value not low");
    AST_OE_SCL_LOW: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data drive changed while bus clock high");
    AST_STROBE_ONE: assert property (write_strobe |=> !write_strobe)
        else $error("write strobe longer than one cycle");
    AST_STROBE_BUSY: assert property (write_strobe |-> busy)
        else $error("write strobe outside a transfer");
    AST_IDLE_QUIET: assert property (!busy |-> !sda_oe)
        else $error("data line driven while idle");
    AST_START_BUSY: assert property (clock_enable && scl_in && $past(scl_in)
        && $past(scl_in, 2) && $fell(sda_in) |-> ##[1:8] busy)
        else $error("start not taken");
    AST_STOP_IDLE: assert property (clock_enable && scl_in && $past(scl_in)
        && $past(scl_in, 2) && $rose(sda_in) |-> ##[1:8] !busy)
        else $error("stop did not end transfer");
    AST_ADDR_QUIET: assert property (!busy && !$past(busy) |-> $stable(mem_addr))
        else $error("pointer moved while idle");

    cover property (write_strobe);
    cover property ($rose(sda_oe) && busy);
    cover property ($fell(busy));
endmodule // pot_port_monitor

bind pot_two_wire_slave_port pot_port_monitor #(.TYPE_CODE(TYPE_CODE),
    .ADDR_WIDTH(ADDR_WIDTH)) u_monitor (.clock(clock), .rstn(rstn),
    .clock_enable(clock_enable), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .addr_select_pin(addr_select_pin), .read_data(read_data),
    .mem_addr(mem_addr), .write_data(write_data), .write_strobe(write_strobe),
    .busy(busy));

// ===== pot_bus_master.sv
// behavioural two-wire bus master facing the slave port
`timescale 1ns/1ps

module pot_bus_master
(
    input wire logic clock,
    input wire logic dev_low,
    output logic scl,
    output wire logic sda
);
    logic m_low;
    int q;

    // pull-up: line high unless someone pulls it low
    assign sda = !(m_low || dev_low);

    initial
    begin
        scl = 1'b1;
        m_low = 1'b0;
        q = 3;
    end

    task automatic wait_q(input int n);
        repeat (n * q) @(negedge clock);
    endtask

    // data set only in clock low phase
    task automatic put_bit(input logic b, output logic seen);
        wait_q(1);
        m_low = !b;
        wait_q(1);
        scl = 1'b1;
        wait_q(1);
        seen = sda;
        wait_q(1);
        scl = 1'b0;
    endtask

    task automatic start();
        wait_q(1);
        m_low = 1'b0;
        wait_q(1);
        scl = 1'b1;
        wait_q(2);
        m_low = 1'b1;
        wait_q(1);
        scl = 1'b0;
    endtask

    task automatic stop();
        wait_q(1);
        m_low = 1'b1;
        wait_q(1);
        scl = 1'b1;
        wait_q(1);
        m_low = 1'b0;
        wait_q(2);
    endtask

    // mack high leaves the ninth bit released (nack or slave ack)
    task automatic byte_io(input logic [7:0] d, input logic mack,
        output logic [7:0] got, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--)
            put_bit(d[i], got[i]);
        put_bit(mack, a);
        ack = !a;
    endtask
endmodule // pot_bus_master

// ===== pot_two_wire_slave_port_tb.sv
// self-checking testbench for the two-wire slave port
`timescale 1ns/1ps

module pot_two_wire_slave_port_tb;
    // ------------------------------------------------
    // wiring
    // ------------------------------------------------
    localparam logic [5:0] TC = 6'h15; // arbitrary type code
    logic clock;
    logic rstn;
    logic addr_select_pin;
    logic scl;
    wire sda;
    logic sda_out;
    logic sda_oe;
    logic [7:0] mem_addr;
    logic [7:0] write_data;
    logic write_strobe;
    logic busy;
    wire [7:0] read_data;
    int error_cnt = 0;
    int n_tests = 0;
    int strobe_cnt = 0;
    logic [7:0] got;
    logic ack;

    // memory stand-in: byte derived from its address
    assign read_data = mem_addr ^ 8'h5a;

    pot_bus_master u_master (.clock(clock), .dev_low(sda_oe), .scl(scl), .sda(sda));

    pot_two_wire_slave_port #(.TYPE_CODE(TC), .ADDR_WIDTH(8)) u_dut (.clock(clock),
        .rstn(rstn), .clock_enable(1'b1), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .addr_select_pin(addr_select_pin), .read_data(read_data),
        .mem_addr(mem_addr), .write_data(write_data), .write_strobe(write_strobe),
        .busy(busy));

    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    always @(posedge clock)
        if (write_strobe === 1'b1)
            strobe_cnt++;

    // ------------------------------------------------
    // checks and scenarios
    // ------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic ctrl(input logic [5:0] tc, input logic sel, input logic dir);
        u_master.start();
        u_master.byte_io({tc, sel, dir}, 1'b1, got, ack);
    endtask

    task automatic t_write;
        ctrl(TC, 1'b1, 1'b0);
        check(ack, 1);
        u_master.byte_io(8'hfe, 1'b1, got, ack);
        check(ack, 1);
        u_master.byte_io(8'h3c, 1'b1, got, ack);
        check(write_data, 8'h3c);
        u_master.byte_io(8'h81, 1'b1, got, ack);
        check(ack, 1);
        check(strobe_cnt, 2);
        check(mem_addr, 8'h00);
        u_master.stop();
        check(busy, 0);
    endtask

    task automatic t_read;
        ctrl(TC, 1'b1, 1'b0);
        u_master.byte_io(8'hfe, 1'b1, got, ack);
        ctrl(TC, 1'b1, 1'b1);
        check(ack, 1);
        u_master.byte_io(8'hff, 1'b0, got, ack);
        check(got, 8'hfe ^ 8'h5a);
        check(sda_out, 0);
        u_master.byte_io(8'hff, 1'b0, got, ack);
        check(got, 8'hff ^ 8'h5a);
        u_master.byte_io(8'hff, 1'b1, got, ack);
        check(got, 8'h00 ^ 8'h5a);
        check(ack, 0);
        u_master.stop();
        check(mem_addr, 8'h01);
    endtask

    task automatic t_refuse;
        ctrl(TC, 1'b0, 1'b0);
        check(ack, 0);
        ctrl(TC ^ 6'h01, 1'b1, 1'b1);
        check(ack, 0);
        check(busy, 0);
        u_master.stop();
        addr_select_pin = 1'b0;
        ctrl(TC, 1'b0, 1'b1);
        check(ack, 1);
        u_master.byte_io(8'hff, 1'b1, got, ack);
        check(got, 8'h01 ^ 8'h5a);
        u_master.stop();
        addr_select_pin = 1'b1;
    endtask

    // slower bus clock, same protocol
    task automatic t_slow;
        u_master.q = 20;
        ctrl(TC, 1'b1, 1'b0);
        check(ack, 1);
        u_master.byte_io(8'h10, 1'b1, got, ack);
        u_master.stop();
        check(mem_addr, 8'h10);
        u_master.q = 3;
    endtask

    task automatic end_of_test;
        $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        rstn = 1'b0;
        addr_select_pin = 1'b1;
        repeat (8) @(negedge clock);
        rstn = 1'b1;
        repeat (4) @(negedge clock);
        check(sda_oe, 0);
        check(sda_out, 0);
        check(mem_addr, 8'h00);
        t_write;
        t_read;
        t_refuse;
        t_slow;
        end_of_test;
    end

    // far beyond the few thousand cycles the scenarios need
    initial
    begin
        #100000;
        error_cnt++;
        $display("mismatch at %0t: watchdog expired", $time);
        end_of_test;
    end
endmodule // pot_two_wire_slave_port_tb
